// ===== pfm_top.sv
// event counter and timebase of the pulse frequency meter with register port
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "pfm_map.svh"

// Behaviour
// [R01] 8-bit event counter counts selected pin edges
// [R02] mode value 7F selects interval, pin clock
// [R03] polarity bit one selects rising edges
// [R04] event pending flag shows request state
// [R05] event enable gates pending request out
// [R06] match A enable gates timebase request
// [R07] select 1,1,0 plus internal gives /128; the code gives /128 for CKS 0,1,1 (3'h3) plus internal
// [R08] match A flag shows compare request
// [R09] 8-bit timebase counter, clock divided 128
// [R10] match when counter equals constant A
// [R11] software captures count after one second
// [R12] software tallies overflows, stops on wrap
// [R13] software two-byte tick count for second
// [R14] event counter overflow sets pending flag
// [R15] software: frequency is tally*256 plus count
// [R16] match A clears counter when configured
// [R17] software clears match flag each interrupt
module pfm_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire pfm_pkg::pfm_bus_req_t bus_i,
  input wire logic event_input_pin_i,
  output logic [7:0] rd_data_o,
  output logic event_irq_o,
  output logic timebase_irq_o
);

  pfm_pkg::pfm_state_t st;
  pfm_pkg::pfm_state_t next_st;
  logic ev_edge;
  logic ev_ext;
  logic ev_tick;
  logic ev_ovf;
  logic tb_run;
  logic tb_tick;
  logic match_a;
  logic tb_clr;
  logic tb_ovf;
  logic [2:0] cks;

  // prescaler bit index for the event counter's internal rates
  function automatic logic [3:0] ev_tap_bit(input logic [2:0] sel);
    logic [3:0] b;
    b = 4'h0;
    unique case (sel)
      3'h0: b = 4'hc;
      3'h1: b = 4'ha;
      3'h2: b = 4'h8;
      3'h3: b = 4'h7;
      3'h4: b = 4'h5;
      3'h5: b = 4'h3;
      3'h6: b = 4'h1;
      3'h7: b = 4'h0;
    endcase
    return b;
  endfunction

  // one cycle before bit b falls: the falling edge of that prescaler stage
  function automatic logic tap(input logic [13:0] p, input logic [3:0] b);
    logic [13:0] m;
    m = (14'h0001 << (b + 4'h1)) - 14'h0001;
    return (p & m) == m;
  endfunction

  assign cks = st.tb_ctl0[`PFM_CKS_HI:`PFM_CKS_LO];
  // the pin is only read after two synchroniser stages
  assign ev_edge = st.pol[`PFM_POL_BIT] ? (st.pin_sync[1] && !st.pin_sync[2]) :
                   (!st.pin_sync[1] && st.pin_sync[2]); // [R03]
  assign ev_ext = st.ev_mode[2:0] == `PFM_EV_SEL_EXT; // [R02]
  assign ev_tick = ev_ext ? ev_edge : tap(st.presc, ev_tap_bit(st.ev_mode[2:0])); // [R01]
  assign ev_ovf = ev_tick && (st.ev_cnt == 8'hff);
  // codes above 3 have no internal source here and stop the timebase
  assign tb_run = (cks != 3'h0) && !cks[2];
  assign tb_tick = tb_run && tap(st.presc,
                   4'({cks[1:0], st.tb_ctl1[`PFM_ICKS_BIT]}) - 4'h1); // [R07] [R09]
  assign match_a = tb_tick && (st.tb_cnt == st.tb_cmp_a); // [R10]
  assign tb_clr = st.tb_ctl0[`PFM_CCLR_HI:`PFM_CCLR_LO] == `PFM_CCLR_MATCH_A;
  assign tb_ovf = tb_tick && (st.tb_cnt == 8'hff) && !(match_a && tb_clr);

  always_comb begin
    next_st = st;
    next_st.pin_sync = {st.pin_sync[1:0], event_input_pin_i};
    next_st.presc = st.presc + 14'h0001;
    if (ev_tick) begin
      if (ev_ovf) begin
        next_st.ev_cnt = st.ev_mode[`PFM_EV_RELOAD_BIT] ? st.ev_reload : 8'h00;
      end else begin
        next_st.ev_cnt = st.ev_cnt + 8'h01; // [R01]
      end
    end
    if (tb_tick) begin
      next_st.tb_cnt = (match_a && tb_clr) ? 8'h00 : st.tb_cnt + 8'h01; // [R16] [R09]
    end
    next_st.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `PFM_ADDR_EV_MODE: next_st.rdata = st.ev_mode;
        `PFM_ADDR_EV_CNT: next_st.rdata = st.ev_cnt;
        `PFM_ADDR_TB_CTL0: next_st.rdata = st.tb_ctl0;
        `PFM_ADDR_TB_STAT: next_st.rdata = st.tb_stat;
        `PFM_ADDR_TB_CMP_A: next_st.rdata = st.tb_cmp_a;
        `PFM_ADDR_TB_CNT: next_st.rdata = st.tb_cnt;
        `PFM_ADDR_TB_CTL1: next_st.rdata = st.tb_ctl1;
        `PFM_ADDR_POL: next_st.rdata = st.pol;
        `PFM_ADDR_IEN: next_st.rdata = st.ien;
        `PFM_ADDR_IRR: next_st.rdata = st.irr;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // flags: writing 0 clears, writing 1 keeps
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        `PFM_ADDR_EV_MODE: next_st.ev_mode = bus_i.wdata; // [R02]
        `PFM_ADDR_EV_CNT: next_st.ev_reload = bus_i.wdata;
        `PFM_ADDR_TB_CTL0: next_st.tb_ctl0 = bus_i.wdata;
        `PFM_ADDR_TB_STAT: next_st.tb_stat = {st.tb_stat[7:5] & bus_i.wdata[7:5],
                                               bus_i.wdata[4:0]};
        `PFM_ADDR_TB_CMP_A: next_st.tb_cmp_a = bus_i.wdata;
        `PFM_ADDR_TB_CNT: next_st.tb_cnt = bus_i.wdata;
        `PFM_ADDR_TB_CTL1: next_st.tb_ctl1 = bus_i.wdata;
        `PFM_ADDR_POL: next_st.pol = bus_i.wdata;
        `PFM_ADDR_IEN: next_st.ien = bus_i.wdata;
        `PFM_ADDR_IRR: next_st.irr = st.irr & bus_i.wdata;
        default: next_st.ien = next_st.ien;
      endcase
    end
    // hardware sets come last so an event beats a same-cycle clear
    if (ev_ovf) begin
      next_st.irr[`PFM_EV_IRQ_BIT] = 1'b1; // [R14] [R04]
    end
    if (match_a) begin
      next_st.tb_stat[`PFM_MATCH_A_FLAG_BIT] = 1'b1; // [R08] [R10]
    end
    if (tb_ovf) begin
      next_st.tb_stat[`PFM_OVF_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rdata;
  assign event_irq_o = st.irr[`PFM_EV_IRQ_BIT] && st.ien[`PFM_EV_IRQ_BIT]; // [R05]
  assign timebase_irq_o = (st.tb_stat[`PFM_MATCH_A_FLAG_BIT] &&
                           st.tb_ctl0[`PFM_MATCH_A_IE_BIT]) || // [R06]
                          (st.tb_stat[`PFM_OVF_FLAG_BIT] && st.tb_ctl0[`PFM_OVF_IE_BIT]);

  // helper: cycles since the last timebase tick under the /128 setting
  logic [7:0] tb_gap;
  logic tb_seen;
  logic tb_doc;
  assign tb_doc = (cks == `PFM_CKS_DIV128) && st.tb_ctl1[`PFM_ICKS_BIT];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tb_gap <= 8'h00;
      tb_seen <= 1'b0;
    end else begin
      tb_gap <= tb_tick ? 8'h00 : (tb_gap == 8'hff ? tb_gap : tb_gap + 8'h01);
      tb_seen <= tb_doc && (tb_seen || tb_tick);
    end
  end

  // write strobes decoded once, shared by the flag and counter checks
  logic wr_irr;
  logic wr_stat;
  logic wr_cnt;
  function automatic logic hit(input pfm_pkg::pfm_bus_req_t b, input logic [15:0] a);
    return b.wr && (b.addr == a);
  endfunction
  assign wr_irr = hit(bus_i, `PFM_ADDR_IRR);
  assign wr_stat = hit(bus_i, `PFM_ADDR_TB_STAT);
  assign wr_cnt = hit(bus_i, `PFM_ADDR_TB_CNT);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  evt_incr_a: assert property (ev_tick && !ev_ovf && !bus_i.wr |=> // [R01]
      st.ev_cnt == $past(st.ev_cnt) + 8'h01)
    else $error("event counter missed an increment");
  ext_mode_a: assert property (st.ev_mode == `PFM_EV_MODE_EXT |-> ev_tick == ev_edge) // [R02]
    else $error("external mode not clocked by pin edges");
  rise_edge_a: assert property (st.pol[`PFM_POL_BIT] && st.pin_sync[1] && // [R03]
      !st.pin_sync[2] && ev_ext |-> ev_tick)
    else $error("rising pin edge not counted");
  ovf_pend_a: assert property (ev_ovf |=> st.irr[`PFM_EV_IRQ_BIT] ##0 // [R14]
      st.ev_cnt == ($past(st.ev_mode[`PFM_EV_RELOAD_BIT]) ? $past(st.ev_reload) : 8'h00))
    else $error("overflow did not set pending flag");
  pend_hold_a: assert property (st.irr[`PFM_EV_IRQ_BIT] && // [R04]
      !(bus_i.wr && bus_i.addr == `PFM_ADDR_IRR) |=> st.irr[`PFM_EV_IRQ_BIT])
    else $error("pending flag dropped without a clear");
  ev_gate_a: assert property (ev_ovf && st.ien[`PFM_EV_IRQ_BIT] && !bus_i.wr // [R05]
      |=> event_irq_o)
    else $error("enabled event request not passed on");
  ev_block_a: assert property (!st.ien[`PFM_EV_IRQ_BIT] |-> !event_irq_o) // [R05]
    else $error("disabled event request leaked");
  tb_gate_a: assert property (match_a && st.tb_ctl0[`PFM_MATCH_A_IE_BIT] && !bus_i.wr // [R06]
      |=> timebase_irq_o)
    else $error("enabled match request not raised");
  tb_rate_a: assert property (tb_tick && tb_seen |-> tb_gap == 8'(`PFM_TB_DIV - 1)) // [R07]
    else $error("timebase tick spacing wrong");
  match_flag_a: assert property (match_a |=> st.tb_stat[`PFM_MATCH_A_FLAG_BIT]) // [R08]
    else $error("match flag not set");
  match_clr_a: assert property (match_a && tb_clr && !bus_i.wr |=> st.tb_cnt == 8'h00) // [R16]
    else $error("counter not cleared on match");

  pol_fall_a: assert property (!st.pol[`PFM_POL_BIT] && st.pin_sync[1] && // [R03]
      !st.pin_sync[2] && ev_ext |-> !ev_tick)
    else $error("rising edge counted in falling mode");

  pend_clr_a: assert property (wr_irr && !bus_i.wdata[`PFM_EV_IRQ_BIT] && !ev_ovf // [R04]
      |=> !st.irr[`PFM_EV_IRQ_BIT])
    else $error("pending flag not cleared");

  pend_read_a: assert property (bus_i.rd && bus_i.addr == `PFM_ADDR_IRR |=> // [R04]
      rd_data_o[`PFM_EV_IRQ_BIT] == $past(st.irr[`PFM_EV_IRQ_BIT]))
    else $error("pending flag read back wrong");

  ev_pass_a: assert property (st.irr[`PFM_EV_IRQ_BIT] && st.ien[`PFM_EV_IRQ_BIT] // [R05]
      |-> event_irq_o)
    else $error("enabled pending request blocked");

  tb_block_a: assert property (!st.tb_ctl0[`PFM_MATCH_A_IE_BIT] && // [R06]
      !st.tb_ctl0[`PFM_OVF_IE_BIT] |-> !timebase_irq_o)
    else $error("disabled timebase request leaked");

  tb_pass_a: assert property (st.tb_stat[`PFM_MATCH_A_FLAG_BIT] && // [R06]
      st.tb_ctl0[`PFM_MATCH_A_IE_BIT] |-> timebase_irq_o)
    else $error("enabled match flag not raised");

  tb_div_a: assert property (tb_doc && tb_tick |-> // [R07]
      st.presc[6:0] == 7'h7f)
    else $error("timebase tick off its divider phase");

  match_hold_a: assert property (st.tb_stat[`PFM_MATCH_A_FLAG_BIT] && !wr_stat // [R08]
      |=> st.tb_stat[`PFM_MATCH_A_FLAG_BIT])
    else $error("match flag dropped without a clear");

  match_drop_a: assert property (wr_stat && !bus_i.wdata[`PFM_MATCH_A_FLAG_BIT] && // [R08]
      !match_a |=> !st.tb_stat[`PFM_MATCH_A_FLAG_BIT])
    else $error("match flag not cleared");

  tb_step_a: assert property (tb_tick && !(match_a && tb_clr) && !wr_cnt |=> // [R09]
      st.tb_cnt == $past(st.tb_cnt) + 8'h01)
    else $error("timebase counter missed a step");

  tb_hold_a: assert property (!tb_tick && !wr_cnt |=> // [R09]
      $stable(st.tb_cnt))
    else $error("timebase counter moved without a tick");

  tb_span_a: assert property (tb_doc && tb_seen |-> // [R09]
      tb_gap < 8'h80)
    else $error("timebase tick overdue");

  tb_cnt_rd_a: assert property (bus_i.rd && bus_i.addr == `PFM_ADDR_TB_CNT |=> // [R09]
      rd_data_o == $past(st.tb_cnt))
    else $error("timebase counter read back wrong");

  match_src_a: assert property ($rose(st.tb_stat[`PFM_MATCH_A_FLAG_BIT]) && // [R10]
      !$past(wr_stat) |-> $past(tb_tick) && $past(st.tb_cnt) == $past(st.tb_cmp_a))
    else $error("match flag set without a match");

  match_keep_a: assert property (match_a && !tb_clr && !wr_cnt |=> // [R16]
      st.tb_cnt == $past(st.tb_cnt) + 8'h01)
    else $error("counter cleared although not configured");

  ev_still_a: assert property (ev_ext && !ev_edge |=> // [R01]
      $stable(st.ev_cnt))
    else $error("event counter moved without a pin edge");

  edge_step_a: assert property (ev_ext && ev_edge && st.ev_cnt != 8'hff |=> // [R01]
      st.ev_cnt == $past(st.ev_cnt) + 8'h01)
    else $error("pin edge not added to the count");

  cnt_rd_a: assert property (bus_i.rd && bus_i.addr == `PFM_ADDR_EV_CNT |=> // [R01]
      rd_data_o == $past(st.ev_cnt))
    else $error("event count read back wrong");

  mode_sel_a: assert property (bus_i.wr && bus_i.addr == `PFM_ADDR_EV_MODE && // [R02]
      bus_i.wdata == `PFM_EV_MODE_EXT |=> ev_ext && !st.ev_mode[`PFM_EV_RELOAD_BIT])
    else $error("mode value did not select pin clock");

  ovf_flag_a: assert property (tb_ovf |=>
      st.tb_stat[`PFM_OVF_FLAG_BIT])
    else $error("timebase overflow flag not set");

  rd_idle_a: assert property (!bus_i.rd |=>
      rd_data_o == 8'h00)
    else $error("read data not idle");

  irq_low_a: assert property (!st.irr[`PFM_EV_IRQ_BIT] |-> // [R04]
      !event_irq_o)
    else $error("event request without pending flag");

  ev_wrap_c: cover property (ev_ovf && ev_ext);
  match_c: cover property (match_a && tb_clr && tb_doc);
  reload_c: cover property (ev_ovf && st.ev_mode[`PFM_EV_RELOAD_BIT]);
  race_c: cover property (match_a && bus_i.wr && bus_i.addr == `PFM_ADDR_TB_STAT);
  pass_c: cover property (ev_ovf && st.ien[`PFM_EV_IRQ_BIT]);
endmodule

// ===== pfm_map.svh
// register offsets, field positions, reset values and counts of the pulse frequency meter
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH
`define PFM_ADDR_EV_MODE 16'hf760
`define PFM_ADDR_EV_CNT 16'hf761
`define PFM_ADDR_TB_CTL0 16'hffa0
`define PFM_ADDR_TB_STAT 16'hffa1
`define PFM_ADDR_TB_CMP_A 16'hffa2
`define PFM_ADDR_TB_CNT 16'hffa4
`define PFM_ADDR_TB_CTL1 16'hffa5
`define PFM_ADDR_POL 16'hfff2
`define PFM_ADDR_IEN 16'hfff5
`define PFM_ADDR_IRR 16'hfff8
`define PFM_RST_BYTE 8'h00
`define PFM_EV_MODE_EXT 8'h7f
`define PFM_EV_SEL_EXT 3'h7
`define PFM_EV_RELOAD_BIT 7
`define PFM_POL_BIT 1
`define PFM_EV_IRQ_BIT 5
`define PFM_MATCH_A_IE_BIT 6
`define PFM_OVF_IE_BIT 5
`define PFM_MATCH_A_FLAG_BIT 6
`define PFM_OVF_FLAG_BIT 5
`define PFM_CCLR_LO 3
`define PFM_CCLR_HI 4
`define PFM_CCLR_MATCH_A 2'h1
`define PFM_CKS_LO 0
`define PFM_CKS_HI 2
`define PFM_ICKS_BIT 0
`define PFM_CKS_DIV128 3'h3
`define PFM_TB_DIV 128
`endif

// ===== pfm_pkg.sv
// types of the pulse frequency meter
package pfm_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfm_bus_req_t;

  typedef struct packed {
    logic [7:0] ev_mode;
    logic [7:0] ev_cnt;
    logic [7:0] ev_reload;
    logic [7:0] tb_ctl0;
    logic [7:0] tb_stat;
    logic [7:0] tb_cmp_a;
    logic [7:0] tb_cnt;
    logic [7:0] tb_ctl1;
    logic [7:0] pol;
    logic [7:0] ien;
    logic [7:0] irr;
    logic [7:0] rdata;
    logic [13:0] presc;
    logic [2:0] pin_sync;
  } pfm_state_t;
endpackage

// ===== pfm_pulse_src.sv
// external pulse source model driving the event input pin
`timescale 1ns/1ns
module pfm_pulse_src (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // each level held hi cycles, so edges never come closer than the sync flops resolve
  task automatic pulses(input int n, input int hi);
    repeat (n) begin
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (hi) @(posedge clk_i);
    end
  endtask
  task automatic level(input logic v);
    pin_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ===== tb.sv
// self-checking bench of the pulse frequency meter
`timescale 1ns/1ns
`include "pfm_map.svh"
module tb;
  logic clk_i;
  logic sys_rst_i;
  pfm_pkg::pfm_bus_req_t bus;
  logic pin;
  logic [7:0] rd_data_o;
  logic ev_irq;
  logic tb_irq;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  logic [7:0] rv;
  logic [7:0] tally;
  logic [15:0] ticks;
  logic [15:0] addrs [11];
  pfm_top i_pfm_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .event_input_pin_i(pin), .rd_data_o(rd_data_o), .event_irq_o(ev_irq),
    .timebase_irq_o(tb_irq));
  pfm_pulse_src i_pfm_pulse_src (.clk_i(clk_i), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // strobe dropped and one more edge let pass, so no task reassigns bus in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    // read data stand only in this cycle, so take them mid-cycle
    @(negedge clk_i);
    rv = rd_data_o;
    chk({8'h00, rv}, {8'h00, e});
    @(posedge clk_i);
  endtask
  task automatic wait_tb();
    int k;
    for (k = 0; k < 5000 && tb_irq !== 1'b1; k++) @(posedge clk_i);
  endtask
  task automatic stop_test();
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    addrs = '{`PFM_ADDR_EV_MODE, `PFM_ADDR_EV_CNT, `PFM_ADDR_TB_CTL0, `PFM_ADDR_TB_STAT,
      `PFM_ADDR_TB_CMP_A, `PFM_ADDR_TB_CNT, `PFM_ADDR_TB_CTL1, `PFM_ADDR_POL,
      `PFM_ADDR_IEN, `PFM_ADDR_IRR, 16'h1234};
    sys_rst_i = 1'b1;
    bus = '0;
    tally = 8'h00;
    ticks = 16'h0000;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (addrs[i]) rd(addrs[i], `PFM_RST_BYTE);
    wr(16'h1234, 8'ha5);
    rd(16'h1234, 8'h00);
    wr(`PFM_ADDR_EV_MODE, `PFM_EV_MODE_EXT);
    rd(`PFM_ADDR_EV_MODE, 8'h7f);
    wr(`PFM_ADDR_POL, 8'h02);
    i_pfm_pulse_src.level(1'b1);
    rd(`PFM_ADDR_EV_CNT, 8'h01);
    i_pfm_pulse_src.level(1'b0);
    rd(`PFM_ADDR_EV_CNT, 8'h01);
    wr(`PFM_ADDR_POL, 8'h00);
    i_pfm_pulse_src.level(1'b1);
    rd(`PFM_ADDR_EV_CNT, 8'h01);
    i_pfm_pulse_src.level(1'b0);
    rd(`PFM_ADDR_EV_CNT, 8'h02);
    wr(`PFM_ADDR_POL, 8'h02);
    i_pfm_pulse_src.pulses(254, 2);
    i_pfm_pulse_src.pulses(5, 4);
    repeat (6) @(posedge clk_i);
    rd(`PFM_ADDR_IRR, 8'h20);
    chk({15'h0000, ev_irq}, 16'h0000);
    wr(`PFM_ADDR_IEN, 8'h20);
    chk({15'h0000, ev_irq}, 16'h0001);
    if (ev_irq === 1'b1) tally++;
    rd(`PFM_ADDR_EV_CNT, 8'h05);
    chk({tally, 8'h00} + {8'h00, rv}, 16'h0105);
    wr(`PFM_ADDR_IRR, 8'h00);
    rd(`PFM_ADDR_IRR, 8'h00);
    chk({15'h0000, ev_irq}, 16'h0000);
    wr(`PFM_ADDR_TB_CMP_A, 8'h20);
    wr(`PFM_ADDR_TB_CTL1, 8'h01);
    wr(`PFM_ADDR_TB_CTL0, 8'h4b);
    wait_tb();
    t1 = cyc;
    chk({15'h0000, tb_irq}, 16'h0001);
    ticks++;
    rd(`PFM_ADDR_TB_STAT, 8'h40);
    rd(`PFM_ADDR_TB_CNT, 8'h00);
    wr(`PFM_ADDR_TB_STAT, 8'h00);
    chk({15'h0000, tb_irq}, 16'h0000);
    wait_tb();
    chk(16'(cyc - t1), 16'h1080);
    ticks++;
    wr(`PFM_ADDR_TB_CTL0, 8'h0b);
    wr(`PFM_ADDR_TB_STAT, 8'h00);
    repeat (4300) @(posedge clk_i);
    chk({15'h0000, tb_irq}, 16'h0000);
    rd(`PFM_ADDR_TB_STAT, 8'h40);
    wr(`PFM_ADDR_IEN, 8'h00);
    rd(`PFM_ADDR_EV_CNT, 8'h05);
    chk(ticks, 16'h0002);
    stop_test();
  end
endmodule
